/* File: msix_pkg.sv */
// Package with register map, layouts and types for the MSI-X interrupt generator.
package msix_pkg;
  localparam int MAX_ENTRIES = 2048;
  localparam int NUM_ENTRIES = 16;
  localparam int IDX_W = 4;
  localparam logic [15:0] TABLE_SIZE = 16'(NUM_ENTRIES - 1);
  localparam logic [11:0] MSG_CTRL_OFFSET = 12'h050;
  localparam logic [15:0] TABLE_BASE = 16'h1000;
  localparam logic [15:0] PEND_BASE = 16'h2000;
  localparam logic [15:0] CTRL_BASE = 16'h0000;
  localparam logic [15:0] INT_STATUS_OFFSET = 16'h0004;
  localparam logic [15:0] INT_CLEAR_OFFSET = 16'h0008;
  localparam logic [15:0] INT_ENABLE_OFFSET = 16'h000C;
  localparam logic [15:0] TX_STATUS_OFFSET = 16'h0010;
  localparam int ENTRY_BYTES = 16;
  localparam int PEND_QWORD_BYTES = 8;
  localparam int PEND_QWORD_BITS = 64;
  localparam int DW_ADDR_LO = 0;
  localparam int DW_ADDR_HI = 1;
  localparam int DW_DATA = 2;
  localparam int DW_VCTRL = 3;
  localparam int VCTRL_MASK_BIT = 0;
  localparam int MSGCTL_ENABLE_BIT = 15;
  localparam int MSGCTL_FMASK_BIT = 14;
  localparam int EV_SENT = 0;
  localparam int EV_HELD = 1;
  localparam int EV_W = 2;
  localparam logic [31:0] VCTRL_RESET = 32'h0000_0001;
  localparam logic [2:0] FMT_3DW = 3'h2;
  localparam logic [2:0] FMT_4DW = 3'h3;

  typedef struct packed {
    logic [2:0] fmt;
    logic [31:0] addrHi;
    logic [31:0] addrLo;
    logic [31:0] data;
  } tx_req_s;

  typedef enum logic [1:0] {IDLE, FETCH, SEND} issue_e;
endpackage : msix_pkg

/* File: msix_pending_array.sv */
// Pending bit array: sets on request, clears on accepted message, and read view.
`timescale 1ns/1ps
module msix_pending_array
  import msix_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [NUM_ENTRIES-1:0] setReq,
  input wire logic clrValid,
  input wire logic [IDX_W-1:0] clrIdx,
  output logic [NUM_ENTRIES-1:0] pending
);
  logic [NUM_ENTRIES-1:0] next_pending;

  // A new request in the clearing cycle wins so no interrupt is lost.
  genvar i;
  generate
    for (i = 0; i < NUM_ENTRIES; i++)
    begin : g_bit
      always_comb
      begin
        next_pending[i] = pending[i];
        if (clrValid && clrIdx == IDX_W'(i))
          next_pending[i] = 1'b0;
        if (setReq[i])
          next_pending[i] = 1'b1;
      end
    end
  endgenerate

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pending <= '0;
    else if (ce)
      pending <= next_pending;
  end
endmodule : msix_pending_array

/* File: msix_interrupt_generator.sv */
// MSI-X interrupt generator: vector table, pending bits, message issuer, Wishbone slave.
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps
module msix_interrupt_generator
  import msix_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [NUM_ENTRIES-1:0] irqReq,
  input wire logic [15:0] msgControl,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [10:0] tableSize,
  output logic txValid,
  input wire logic txReady,
  output tx_req_s txReq,
  output logic irq
);
  logic [31:0] vtable [NUM_ENTRIES][4];
  logic [31:0] next_vtable [NUM_ENTRIES][4];
  logic [NUM_ENTRIES-1:0] pending;
  logic [EV_W-1:0] intStatus, next_intStatus, intEnable, next_intEnable;
  logic [31:0] next_datOut;
  logic next_ack;
  issue_e state, next_state;
  logic [IDX_W-1:0] scanIdx, next_scanIdx, curIdx, next_curIdx;
  tx_req_s next_txReq;
  logic [15:0] sentCount, next_sentCount;
  logic clrValid, wbReq, inTable, inPend, isCtrl;
  logic [IDX_W-1:0] wIdx;
  logic [1:0] wDw;
  logic fnEnable, fnMask, entryMasked;

  assign tableSize = TABLE_SIZE[10:0];
  assign fnEnable = msgControl[MSGCTL_ENABLE_BIT];
  assign fnMask = msgControl[MSGCTL_FMASK_BIT];

  assign wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Table window is 4 KB aligned; entry index and dword are cut from the offset.
  assign inTable = wb_adr_i[15:12] == TABLE_BASE[15:12]
    && wb_adr_i[11:4] < 8'(NUM_ENTRIES);
  assign wIdx = wb_adr_i[4+IDX_W-1:4];
  assign wDw = wb_adr_i[3:2];
  assign inPend = wb_adr_i[15:12] == PEND_BASE[15:12] && wb_adr_i[11:3] == 9'h000;
  assign isCtrl = wb_adr_i[15:12] == CTRL_BASE[15:12];

  msix_pending_array msix_pending_array_i (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .setReq(irqReq),
    .clrValid(clrValid),
    .clrIdx(curIdx),
    .pending(pending)
  );

  // Table writes: byte-enabled, one dword per access.
  // Partial writes let software unmask a vector without touching its other bits.
  always_comb
  begin
    next_vtable = vtable;
    if (wbReq && wb_we_i && inTable)
    begin
      for (int b = 0; b < 4; b++)
        if (wb_sel_i[b])
          next_vtable[wIdx][wDw][b*8 +: 8] = wb_dat_i[b*8 +: 8];
    end
  end

  // Every entry comes out of reset masked, so nothing is sent before it is programmed.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int e = 0; e < NUM_ENTRIES; e++)
      begin
        vtable[e][DW_ADDR_LO] <= '0;
        vtable[e][DW_ADDR_HI] <= '0;
        vtable[e][DW_DATA] <= '0;
        vtable[e][DW_VCTRL] <= VCTRL_RESET;
      end
    end
    else if (ce)
      vtable <= next_vtable;
  end

  // Bus answer: mapped or not, every access is acknowledged one cycle after it is taken.
  // Read data is registered, so it stands unchanged until the next read.
  always_comb
  begin
    next_ack = wbReq;
    next_datOut = wb_dat_o;
    if (wbReq && !wb_we_i)
    begin
      next_datOut = '0;
      if (inTable)
        next_datOut = vtable[wIdx][wDw];
      else if (inPend)
        // Qword 0 holds bits 0..63; dword reads pick the half at bit 2.
        next_datOut = wb_adr_i[2] ? 32'h0000_0000
          : 32'(pending);
      else if (wb_adr_i == 16'(MSG_CTRL_OFFSET))
        next_datOut = {16'h0000, msgControl[15:11], tableSize};
      else if (wb_adr_i == INT_STATUS_OFFSET)
        next_datOut = 32'(intStatus);
      else if (wb_adr_i == INT_ENABLE_OFFSET)
        next_datOut = 32'(intEnable);
      else if (wb_adr_i == TX_STATUS_OFFSET)
        next_datOut = {12'h000, 1'(state != IDLE), curIdx[2:0], sentCount};
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end
    else if (ce)
    begin
      wb_ack_o <= next_ack;
      wb_dat_o <= next_datOut;
    end
  end

  // Interrupt registers: an event in the clearing cycle wins, so no event is lost.
  always_comb
  begin
    next_intStatus = intStatus;
    next_intEnable = intEnable;
    if (wbReq && wb_we_i && isCtrl)
    begin
      if (wb_adr_i == INT_CLEAR_OFFSET)
        next_intStatus = intStatus & ~wb_dat_i[EV_W-1:0];
      if (wb_adr_i == INT_ENABLE_OFFSET)
        next_intEnable = wb_dat_i[EV_W-1:0];
    end
    if (clrValid)
      next_intStatus[EV_SENT] = 1'b1;
    if (state == FETCH && entryMasked)
      next_intStatus[EV_HELD] = 1'b1;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      intStatus <= '0;
      intEnable <= '0;
    end
    else if (ce)
    begin
      intStatus <= next_intStatus;
      intEnable <= next_intEnable;
    end
  end

  assign irq = |(intStatus & intEnable);

  // Issuer: round-robin scan of pending bits, fetch entry, check mask, send.
  assign entryMasked = vtable[curIdx][DW_VCTRL][VCTRL_MASK_BIT] || fnMask;
  assign clrValid = state == SEND && txValid && txReady;
  assign txValid = state == SEND;

  always_comb
  begin
    next_state = state;
    next_scanIdx = scanIdx;
    next_curIdx = curIdx;
    next_txReq = txReq;
    next_sentCount = sentCount;
    unique case (state)
      IDLE:
      begin
        next_scanIdx = scanIdx + 1'b1;
        if (pending[scanIdx] && fnEnable)
        begin
          next_curIdx = scanIdx;
          next_state = FETCH;
        end
      end
      FETCH:
      begin
        // Enable is checked again here, as it may drop between scan and fetch.
        if (entryMasked || !fnEnable)
          // Vector stays pending and is revisited, so unmasking later sends it.
          next_state = IDLE;
        else
        begin
          next_txReq.addrLo = vtable[curIdx][DW_ADDR_LO];
          next_txReq.addrHi = vtable[curIdx][DW_ADDR_HI];
          next_txReq.data = vtable[curIdx][DW_DATA];
          next_txReq.fmt = (vtable[curIdx][DW_ADDR_HI] == 32'h0000_0000)
            ? FMT_3DW : FMT_4DW;
          next_state = SEND;
        end
      end
      SEND:
      begin
        if (txReady)
        begin
          next_sentCount = sentCount + 1'b1;
          next_state = IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state <= IDLE;
      scanIdx <= '0;
      curIdx <= '0;
      txReq <= '0;
      sentCount <= '0;
    end
    else if (ce)
    begin
      state <= next_state;
      scanIdx <= next_scanIdx;
      curIdx <= next_curIdx;
      txReq <= next_txReq;
      sentCount <= next_sentCount;
    end
  end
endmodule : msix_interrupt_generator

/* File: msix_gen_props.sv */
// Port checker for the interrupt generator.
`timescale 1ns/1ps
module msix_gen_props
  import msix_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [NUM_ENTRIES-1:0] irqReq,
  input wire logic [15:0] msgControl,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [10:0] tableSize,
  input wire logic txValid,
  input wire logic txReady,
  input wire tx_req_s txReq,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [15:0] ctlPrev;
  // Control word of the previous cycle, for the refusal check.
  always_ff @(posedge clk)
    ctlPrev <= msgControl;
  sequence sTake;
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce;
  endsequence
  sequence sPulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  chk_ack_single: assert property (sTake |=> sPulse) else $error("ack not one pulse");
  chk_unmapped_zero: assert property (sTake ##0 (!wb_we_i && wb_adr_i == 16'h3000)
    |=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  chk_size_read: assert property (sTake ##0 (!wb_we_i && wb_adr_i == 16'h0050)
    |=> wb_dat_o[10:0] == 11'h00F) else $error("table size read wrong");
  chk_size_port: assert property (tableSize == 11'(NUM_ENTRIES - 1)) else $error("size port");
  chk_tx_hold: assert property (txValid && !txReady && ce |=> txValid && $stable(txReq))
    else $error("request not held");
  chk_tx_format: assert property (txValid |-> txReq.fmt == (txReq.addrHi == 32'h0 ?
    FMT_3DW : FMT_4DW)) else $error("header size wrong");
  chk_tx_gap: assert property (txValid && txReady && ce |=> !txValid [*2])
    else $error("valid after accept");
  chk_tx_refuse: assert property ($rose(txValid) |->
    ctlPrev[MSGCTL_ENABLE_BIT] && !ctlPrev[MSGCTL_FMASK_BIT])
    else $error("message while disabled");
  chk_irq_off: assert property (sTake ##0 (wb_we_i && wb_adr_i == 16'h000C &&
    wb_sel_i == 4'hF && wb_dat_i == 32'h0) |=> !irq) else $error("irq while disabled");
endmodule : msix_gen_props
bind msix_interrupt_generator msix_gen_props msix_gen_props_i (.*);

/* File: msix_tx_sink.sv */
// Transmit sink that takes messages at once or after a stall.
`timescale 1ns/1ps
module msix_tx_sink
  import msix_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic txValid,
  input wire tx_req_s txReq,
  output logic txReady,
  output tx_req_s got,
  output logic [7:0] nGot
);
  logic [1:0] waitCnt;
  // A slow sink stalls three cycles so the issuer must hold its request.
  assign txReady = txValid && (!slow || waitCnt == 2'h3);
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      waitCnt <= 2'h0;
      nGot <= 8'h0;
      got <= '0;
    end
    else
    begin
      waitCnt <= (txValid && !txReady) ? waitCnt + 2'h1 : 2'h0;
      if (txValid && txReady)
      begin
        got <= txReq;
        nGot <= nGot + 8'h1;
      end
    end
  end
endmodule : msix_tx_sink

/* File: msix_interrupt_generator_tb.sv */
// Testbench for the interrupt generator with a transmit sink.
`timescale 1ns/1ps
module msix_interrupt_generator_tb;
  import msix_pkg::*;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, slow = 1'b0, ce = 1'b1;
  logic [15:0] adr = 16'h0, irqReq = 16'h0, ctl = 16'h8000;
  logic [31:0] datI = 32'h0, datO, q;
  logic ack, txValid, txReady, irq;
  logic [10:0] tableSize;
  logic [7:0] nGot;
  tx_req_s txReq, got;
  int errors = 0, n_tests = 0;
  always #50 clk = ~clk;
  msix_interrupt_generator msix_interrupt_generator_i (.clk(clk), .rst(rst), .ce(ce),
    .irqReq(irqReq), .msgControl(ctl), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack),
    .tableSize(tableSize), .txValid(txValid), .txReady(txReady), .txReq(txReq), .irq(irq));
  msix_tx_sink msix_tx_sink_i (.clk(clk), .rst(rst), .slow(slow), .txValid(txValid),
    .txReq(txReq), .txReady(txReady), .got(got), .nGot(nGot));
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    datI <= d;
    // Request and data stand until the rising edge at which ack is sampled high.
    do @(posedge clk); while (ack !== 1'b1);
    q = datO;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic pulse(input logic [15:0] v, input logic [7:0] k);
    @(posedge clk);
    irqReq <= v;
    @(posedge clk);
    irqReq <= 16'h0;
    // Slow sinks and a full scan stay far under this bound.
    for (int i = 0; i < 60 && nGot !== k; i++) @(negedge clk);
  endtask : pulse
  task automatic t_regs;
    wb(1'b0, 16'h0050, 32'h0);
    chk("size", q, 32'h0000_800F);
    chk("sizeport", 32'(tableSize), 32'h0000_000F);
    wb(1'b0, 16'h103C, 32'h0);
    chk("vctrl3", q, VCTRL_RESET);
    wb(1'b1, 16'h3000, 32'hFFFF_FFFF);
    wb(1'b0, 16'h3000, 32'h0);
    chk("unmapped", q, 32'h0);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_send;
    wb(1'b1, 16'h000C, 32'h3);
    wb(1'b1, 16'h1050, 32'h0000_1000);
    wb(1'b1, 16'h1058, 32'h0000_00A5);
    wb(1'b1, 16'h105C, 32'h0);
    pulse(16'h0020, 8'h1);
    chk("fmt", 32'(got.fmt), 32'(FMT_3DW));
    chk("addr", got.addrLo, 32'h0000_1000);
    chk("data", got.data, 32'h0000_00A5);
    wb(1'b0, 16'h2000, 32'h0);
    chk("pend", q, 32'h0);
    wb(1'b0, 16'h0004, 32'h0);
    chk("status", q, 32'h1);
    chk("irq", 32'(irq), 32'h1);
    wb(1'b1, 16'h0008, 32'h3);
    chk("irqclr", 32'(irq), 32'h0);
    $display("t_send done");
  endtask : t_send
  task automatic t_mask;
    slow <= 1'b1;
    wb(1'b1, 16'h1090, 32'h0000_2000);
    wb(1'b1, 16'h1094, 32'h0000_0001);
    pulse(16'h0200, 8'h2);
    chk("held", 32'(nGot), 32'h1);
    wb(1'b0, 16'h2000, 32'h0);
    chk("pend9", q, 32'h0000_0200);
    chk("irqheld", 32'(irq), 32'h1);
    wb(1'b0, 16'h2004, 32'h0);
    chk("pendhi", q, 32'h0);
    wb(1'b1, 16'h000C, 32'h0);
    chk("irqmask", 32'(irq), 32'h0);
    wb(1'b1, 16'h109C, 32'h0);
    pulse(16'h0, 8'h2);
    chk("fmt4", 32'(got.fmt), 32'(FMT_4DW));
    chk("hi", got.addrHi, 32'h1);
    $display("t_mask done");
  endtask : t_mask
  task automatic t_func;
    @(posedge clk);
    ctl <= 16'hC000;
    wb(1'b1, 16'h1030, 32'h0000_3000);
    wb(1'b1, 16'h103C, 32'h0);
    pulse(16'h0008, 8'h3);
    chk("fmask", 32'(nGot), 32'h2);
    wb(1'b0, 16'h2000, 32'h0);
    chk("pend3", q, 32'h0000_0008);
    @(posedge clk);
    ctl <= 16'h0000;
    pulse(16'h0, 8'h3);
    chk("fnoff", 32'(nGot), 32'h2);
    @(posedge clk);
    ctl <= 16'h8000;
    pulse(16'h0, 8'h3);
    chk("fnaddr", got.addrLo, 32'h0000_3000);
    chk("fnfmt", 32'(got.fmt), 32'(FMT_3DW));
    $display("t_func done");
  endtask : t_func
  task automatic t_freeze;
    @(posedge clk);
    ce <= 1'b0;
    pulse(16'h0010, 8'h4);
    chk("frozen", 32'(nGot), 32'h3);
    @(posedge clk);
    ce <= 1'b1;
    wb(1'b0, 16'h2000, 32'h0);
    chk("nolatch", q, 32'h0);
    $display("t_freeze done");
  endtask : t_freeze
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_send();
    t_mask();
    t_func();
    t_freeze();
    test_done();
  end
  initial
  begin
    repeat (3000) @(posedge clk);
    errors++;
    test_done();
  end
endmodule : msix_interrupt_generator_tb
